// ===== hw/hash_ctx_pkg.sv
// Shared constants for the hash context suspend and resume block
package hash_ctx_pkg;
    // Bus and storage widths
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int CSR_NUM = 54;
    localparam int FIFO_DEPTH = 16;
    localparam int STATE_WORDS = 8;
    localparam int BLOCK_ROUNDS = 16;
    // Context word indexes: word count, FIFO words, state
    localparam logic [5:0] COUNT_IDX = 6'h15;
    localparam logic [5:0] FIFO_BASE_IDX = 6'h16;
    localparam logic [4:0] FIFO_FULL_CNT = 5'h10;
    // Register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] DATA_OFS = 12'h004;
    localparam logic [11:0] START_OFS = 12'h008;
    localparam logic [11:0] MASK_OFS = 12'h020;
    localparam logic [11:0] STAT_OFS = 12'h024;
    localparam logic [11:0] CSR_OFS = 12'h100;
    localparam logic [11:0] CSR_END_OFS = 12'h1d8;
    // Control register fields
    localparam int CTRL_INIT_BIT = 2;
    localparam int CTRL_DMA_BIT = 3;
    localparam int CTRL_HMAC_BIT = 6;
    localparam logic [31:0] CTRL_WR_MASK = 32'h0000_0048;
    // Start register fields
    localparam int START_FINAL_BIT = 8;
    localparam logic [31:0] START_WR_MASK = 32'h0000_001f;
    // Status register fields
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_INRDY_BIT = 1;
    localparam int STAT_BUSY_BIT = 3;
    localparam int STAT_CNT_LSB = 8;
    localparam int IRQ_W = 2;
    // Values after reset
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] START_RST = 32'h0000_0000;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [1:0] FLAGS_RST = 2'h0;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hw/hash_round_seq.sv
// Round sequencer that paces one block computation
`timescale 1ns/1ps
module hash_round_seq #(
    parameter int ROUNDS = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic init_in,
    output logic busy_out,
    output logic [3:0] round_out,
    output logic last_out
);
    // Busy from start to the end of the last round; init aborts
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_out <= 1'b0;
            round_out <= 4'h0;
        end else if (init_in) begin
            busy_out <= 1'b0;
            round_out <= 4'h0;
        end else if (start_in && !busy_out) begin
            busy_out <= 1'b1;
            round_out <= 4'h0;
        end else if (busy_out) begin
            // Drop busy only after the final round
            if (last_out) begin
                busy_out <= 1'b0;
            end
            round_out <= round_out + 4'h1;
        end
    end

    // Final round of the block
    assign last_out = busy_out && (round_out == 4'(ROUNDS - 1));
endmodule // hash_round_seq

// ===== hw/hash_context_swap.sv
// Hash processor core with saveable context, AXI4-Lite registers
`timescale 1ns/1ps
module hash_context_swap
    import hash_ctx_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [11:0] axi_awaddr_in,
    input wire logic axi_awvalid_in,
    output logic axi_awready_out,
    input wire logic [31:0] axi_wdata_in,
    input wire logic [3:0] axi_wstrb_in,
    input wire logic axi_wvalid_in,
    output logic axi_wready_out,
    output logic [1:0] axi_bresp_out,
    output logic axi_bvalid_out,
    input wire logic axi_bready_in,
    input wire logic [11:0] axi_araddr_in,
    input wire logic axi_arvalid_in,
    output logic axi_arready_out,
    output logic [31:0] axi_rdata_out,
    output logic [1:0] axi_rresp_out,
    output logic axi_rvalid_out,
    input wire logic axi_rready_in,
    input wire logic [31:0] dma_word_in,
    input wire logic dma_valid_in,
    output logic dma_ready_out,
    output logic busy_out,
    output logic irq_out
);
    logic aw_held_r; // Write address captured
    logic [11:0] awaddr_r;
    logic w_held_r; // Write data captured
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_go; // Both halves present, perform write
    logic [31:0] ctrl_r; // control_reg
    logic [31:0] start_r; // start_reg
    logic [1:0] mask_r; // irq_mask_reg
    logic [1:0] flags_r; // Sticky status flags
    logic [1:0] flag_set;
    logic final_pend_r; // Final digest requested
    logic [31:0] csr_r [CSR_NUM]; // context_swap_regs
    logic [4:0] fifo_word_count;
    logic dma_feed_enable;
    logic init_pulse;
    logic wr_ctrl, wr_data, wr_start, wr_mask, wr_stat, wr_csr;
    logic [5:0] wr_idx;
    logic can_accept, push, start_blk;
    logic [31:0] push_word;
    logic busy, last;
    logic [3:0] round;
    logic [5:0] src_idx; // FIFO word read this round
    logic [2:0] dst_idx; // State word updated this round
    logic [2:0] mix_idx;
    logic [31:0] rd_val;
    logic rd_ok;
    logic [11:0] rd_off;

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    // True for an aligned address inside the context window
    function automatic logic csr_hit(input logic [11:0] a);
        return (a >= CSR_OFS) && (a < CSR_END_OFS) && (a[1:0] == 2'h0);
    endfunction

    // Word index inside the context window
    function automatic logic [5:0] csr_index(input logic [11:0] a);
        logic [11:0] d;
        d = a - CSR_OFS;
        return d[7:2];
    endfunction

    // Address and data may arrive in either order
    assign axi_awready_out = !aw_held_r && !axi_bvalid_out;
    assign axi_wready_out = !w_held_r && !axi_bvalid_out;
    assign wr_go = aw_held_r && w_held_r && !axi_bvalid_out;

    // Write channel capture and response
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_held_r <= 1'b0;
            awaddr_r <= 12'h000;
            w_held_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            axi_bvalid_out <= 1'b0;
            axi_bresp_out <= RESP_OKAY;
        end else begin
            if (axi_awvalid_in && axi_awready_out) begin
                aw_held_r <= 1'b1;
                awaddr_r <= axi_awaddr_in;
            end
            if (axi_wvalid_in && axi_wready_out) begin
                w_held_r <= 1'b1;
                wdata_r <= axi_wdata_in;
                wstrb_r <= axi_wstrb_in;
            end
            if (wr_go) begin
                // Unmapped addresses answer with a slave error
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                axi_bvalid_out <= 1'b1;
                axi_bresp_out <= (wr_ctrl || wr_data || wr_start ||
                    wr_mask || wr_stat || wr_csr) ? RESP_OKAY : RESP_SLVERR;
            end else if (axi_bready_in) begin
                axi_bvalid_out <= 1'b0;
            end
        end
    end

    // Write decode
    assign wr_ctrl = wr_go && (awaddr_r == CTRL_OFS);
    assign wr_data = wr_go && (awaddr_r == DATA_OFS);
    assign wr_start = wr_go && (awaddr_r == START_OFS);
    assign wr_mask = wr_go && (awaddr_r == MASK_OFS);
    assign wr_stat = wr_go && (awaddr_r == STAT_OFS);
    assign wr_csr = wr_go && csr_hit(awaddr_r);
    assign wr_idx = csr_index(awaddr_r);
    assign init_pulse = wr_ctrl && wstrb_r[0] &&
        wdata_r[CTRL_INIT_BIT];
    assign dma_feed_enable = ctrl_r[CTRL_DMA_BIT];
    assign fifo_word_count = csr_r[COUNT_IDX][4:0];

    // Control and start registers; init and final bits self-clear
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_r <= CTRL_RST;
            start_r <= START_RST;
            mask_r <= MASK_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & CTRL_WR_MASK;
            end
            if (wr_start) begin
                start_r <= merge(start_r, wdata_r, wstrb_r) & START_WR_MASK;
            end
            if (wr_mask && wstrb_r[0]) begin
                mask_r <= wdata_r[IRQ_W-1:0];
            end
        end
    end

    // Final digest request waits for the block engine
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            final_pend_r <= 1'b0;
        end else if (init_pulse) begin
            final_pend_r <= 1'b0;
        end else if (wr_start && wstrb_r[1] && wdata_r[START_FINAL_BIT]) begin
            final_pend_r <= 1'b1;
        end else if (last) begin
            final_pend_r <= 1'b0;
        end
    end

    // Input accepted only when idle and the FIFO has room
    assign start_blk = !busy && !init_pulse &&
        ((fifo_word_count == FIFO_FULL_CNT) || final_pend_r);
    assign can_accept = !busy && !start_blk && !final_pend_r &&
        !init_pulse && (fifo_word_count != FIFO_FULL_CNT);
    assign dma_ready_out = dma_feed_enable && can_accept;
    assign push = dma_feed_enable ? (dma_valid_in && can_accept) :
        (wr_data && can_accept);
    assign push_word = dma_feed_enable ? dma_word_in : wdata_r;

    // Block engine pacing
    hash_round_seq #(
        .ROUNDS(BLOCK_ROUNDS)
    ) u_seq (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .start_in(start_blk),
        .init_in(init_pulse),
        .busy_out(busy),
        .round_out(round),
        .last_out(last)
    );
    assign busy_out = busy;

    // Round operand indexes
    assign src_idx = FIFO_BASE_IDX + {2'h0, round};
    assign dst_idx = round[2:0];
    assign mix_idx = round[2:0] + 3'h1;

    // Context words: init clears, bus restores, FIFO fills, rounds mix
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < CSR_NUM; i++) begin
                csr_r[i] <= 32'h0000_0000;
            end
        end else if (init_pulse) begin
            for (int i = 0; i < CSR_NUM; i++) begin
                csr_r[i] <= 32'h0000_0000;
            end
        end else begin
            if (wr_csr && !busy) begin
                csr_r[wr_idx] <= merge(csr_r[wr_idx], wdata_r,
                    wstrb_r);
            end
            if (push) begin
                // FIFO words live in the swap area, count in its word
                csr_r[FIFO_BASE_IDX + {1'b0, fifo_word_count}] <= push_word;
                csr_r[COUNT_IDX] <= {27'h0, fifo_word_count + 5'h1};
            end
            if (busy) begin
                csr_r[dst_idx] <= csr_r[dst_idx] + ({csr_r[src_idx][26:0],
                    csr_r[src_idx][31:27]} ^ csr_r[mix_idx]);
            end
            if (last) begin
                csr_r[COUNT_IDX] <= 32'h0000_0000;
            end
        end
    end

    // Events at block end: digest done or ready for more input
    assign flag_set[STAT_DONE_BIT] = last && final_pend_r;
    assign flag_set[STAT_INRDY_BIT] = last && !final_pend_r;

    // Sticky flags, write one to clear, a new event wins
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            flags_r <= FLAGS_RST;
        end else if (init_pulse) begin
            flags_r <= FLAGS_RST;
        end else if (wr_stat && wstrb_r[0]) begin
            flags_r <= (flags_r & ~wdata_r[IRQ_W-1:0]) | flag_set;
        end else begin
            flags_r <= flags_r | flag_set;
        end
    end
    assign irq_out = |(flags_r & mask_r);

    // Read data mux
    assign rd_off = axi_araddr_in;
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        if (rd_off == CTRL_OFS) begin
            rd_val = ctrl_r;
        end else if (rd_off == DATA_OFS) begin
            rd_val = 32'h0000_0000;
        end else if (rd_off == START_OFS) begin
            rd_val = start_r;
        end else if (rd_off == MASK_OFS) begin
            rd_val = {30'h0, mask_r};
        end else if (rd_off == STAT_OFS) begin
            // Word count lets software skip unused FIFO words
            rd_val[IRQ_W-1:0] = flags_r;
            rd_val[STAT_BUSY_BIT] = busy;
            rd_val[STAT_CNT_LSB +: 5] = fifo_word_count;
        end else if (csr_hit(rd_off)) begin
            rd_val = csr_r[csr_index(rd_off)];
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Read channel: one read at a time, data held until taken
    assign axi_arready_out = !axi_rvalid_out;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            axi_rvalid_out <= 1'b0;
            axi_rdata_out <= 32'h0000_0000;
            axi_rresp_out <= RESP_OKAY;
        end else if (axi_arvalid_in && axi_arready_out) begin
            axi_rvalid_out <= 1'b1;
            axi_rdata_out <= rd_val;
            axi_rresp_out <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (axi_rready_in) begin
            axi_rvalid_out <= 1'b0;
        end
    end

    // Busy holds for the first 8 rounds of a block and falls only after the last round or init
    busy_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(busy) && !init_pulse |-> busy[*8] ##0 (round == 4'h7))
        else $error("busy dropped early in block");
    busy_end_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(busy) |-> $past(last) || $past(init_pulse))
        else $error("busy fell before last round");
    init_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
        init_pulse |=> !busy && fifo_word_count == 5'h00 && flags_r == 2'h0)
        else $error("init did not reset processor");
    dma_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !dma_feed_enable |-> !dma_ready_out)
        else $error("dma ready while feed disabled");
    no_push_busy_a: assert property (@(posedge clk_in) disable iff (rst_in)
        busy && !last && !init_pulse |=> $stable(fifo_word_count))
        else $error("word count moved during block");
    done_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
        last && final_pend_r |=> flags_r[STAT_DONE_BIT] && !busy)
        else $error("digest done flag not set");
    ready_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
        last && !final_pend_r |=> flags_r[STAT_INRDY_BIT] && !busy)
        else $error("input ready flag not set");
    count_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
        last |=> fifo_word_count == 5'h00)
        else $error("word count not cleared after block");
    full_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !busy && fifo_word_count == FIFO_FULL_CNT && !init_pulse |=> busy)
        else $error("full FIFO did not start block");
    csr_restore_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_csr && !busy && wstrb_r == 4'hf && !push && !init_pulse &&
        wr_idx != COUNT_IDX |=> csr_r[$past(wr_idx)] == $past(wdata_r))
        else $error("context word not restored");
endmodule // hash_context_swap

// ===== sim/dma_word_source.sv
// Behavioural DMA source offering message words to the feed port
`timescale 1ns/1ps
module dma_word_source (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic chan_on_in,
    input wire logic slow_in,
    input wire logic ready_in,
    output logic [31:0] word_out,
    output logic valid_out,
    output logic [7:0] sent_out
);
    // Message word for a stream position
    function automatic logic [31:0] pattern(input logic [7:0] pos);
        return {8'h6b, pos, 8'h3c, ~pos};
    endfunction

    // Offer held until taken; toggling lines when nothing is offered
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            valid_out <= 1'b0;
            word_out <= 32'h0000_0000;
            sent_out <= 8'h00;
        end else if (!chan_on_in) begin
            // Channel switched off ahead of the feed enable
            valid_out <= 1'b0;
            word_out <= ~word_out;
        end else if (valid_out && ready_in) begin
            // Resume carries on from the next untaken word
            sent_out <= sent_out + 8'h01;
            valid_out <= !slow_in;
            word_out <= slow_in ? ~word_out : pattern(sent_out + 8'h01);
        end else if (!valid_out) begin
            // Offer the next word
            valid_out <= 1'b1;
            word_out <= pattern(sent_out);
        end
    end
endmodule // dma_word_source

// ===== sim/hash_context_swap_bench.sv
// Self-checking bench for the hash context swap block
`timescale 1ns/1ps
module hash_context_swap_bench;
    import hash_ctx_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, chan_on = 1'b0, slow = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid, busy, irq;
    logic dma_ready, dma_valid;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, dma_word, rd;
    logic [7:0] sent;
    logic [31:0] ctx [0:53];
    int miscompares = 0;
    int cmp_count = 0;

    // Design under test
    hash_context_swap u_hash_context_swap (.clk_in(clk_in),
        .rst_in(rst_in), .axi_awaddr_in(awaddr), .axi_awvalid_in(awvalid),
        .axi_awready_out(awready), .axi_wdata_in(wdata),
        .axi_wstrb_in(4'hf), .axi_wvalid_in(wvalid),
        .axi_wready_out(wready), .axi_bresp_out(bresp),
        .axi_bvalid_out(bvalid), .axi_bready_in(bready),
        .axi_araddr_in(araddr), .axi_arvalid_in(arvalid),
        .axi_arready_out(arready), .axi_rdata_out(rdata),
        .axi_rresp_out(rresp), .axi_rvalid_out(rvalid),
        .axi_rready_in(rready), .dma_word_in(dma_word),
        .dma_valid_in(dma_valid), .dma_ready_out(dma_ready),
        .busy_out(busy), .irq_out(irq));

    // Far-side word source
    dma_word_source u_dma_word_source (.clk_in(clk_in), .rst_in(rst_in),
        .chan_on_in(chan_on), .slow_in(slow), .ready_in(dma_ready),
        .word_out(dma_word), .valid_out(dma_valid), .sent_out(sent));

    // 40 MHz clock
    always #12.5 clk_in = ~clk_in;

    // Compare and count
    task chk(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Bus write: address and data offered together, wait for response
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic got;
        got = 1'b0;
        @(posedge clk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got) begin
            @(posedge clk_in);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                got = 1'b1;
                rs = bresp;
                bready <= 1'b0;
            end
        end
    endtask

    // Bus read into rd and rs
    task rd_reg(input logic [11:0] a);
        logic got;
        got = 1'b0;
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got) begin
            @(posedge clk_in);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                got = 1'b1;
                rd = rdata;
                rs = rresp;
                rready <= 1'b0;
            end
        end
    endtask

    // Poll one status bit until it reaches a level
    task poll(input int b, input logic v);
        int n;
        n = 0;
        do begin
            rd_reg(STAT_OFS);
            n++;
        end while (rd[b] !== v && n < 60);
    endtask

    // Wait for busy, then count the edges it stays high
    task wait_busy(output int len);
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 60) begin
            @(posedge clk_in);
            n++;
        end
        len = 0;
        while (busy === 1'b1 && len < 60) begin
            @(posedge clk_in);
            len++;
        end
    endtask

    // Register values after reset and unmapped places
    task reset_values;
        rd_reg(CTRL_OFS);
        chk("ctrl", rd, CTRL_RST);
        rd_reg(START_OFS);
        chk("start", rd, START_RST);
        rd_reg(MASK_OFS);
        chk("mask", rd, {30'h0, MASK_RST});
        rd_reg(STAT_OFS);
        chk("status", rd, 32'h0000_0000);
        rd_reg(12'h010);
        chk("read unmapped", {30'h0, rs}, {30'h0, RESP_SLVERR});
        wr(CSR_END_OFS, 32'h1234_5678);
        chk("write unmapped", {30'h0, rs}, {30'h0, RESP_SLVERR});
    endtask

    // CPU-fed block, ready flag, interrupt raise and clear
    task cpu_block;
        int len;
        wr(CTRL_OFS, 32'h0000_0004);
        wr(MASK_OFS, 32'h0000_0002);
        chk("write okay", {30'h0, rs}, {30'h0, RESP_OKAY});
        for (int i = 0; i < 16; i++) wr(DATA_OFS, 32'h1000_0000 + i);
        wait_busy(len);
        chk("busy span", 32'(len), 32'(BLOCK_ROUNDS));
        rd_reg(STAT_OFS);
        chk("status ready", rd, 32'h0000_0002);
        chk("irq set", {31'h0, irq}, 32'h1);
        wr(STAT_OFS, 32'h0000_0002);
        chk("irq clear", {31'h0, irq}, 32'h0);
    endtask

    // Final request on a partial FIFO; done flag stays masked
    task final_digest;
        int len;
        for (int i = 0; i < 3; i++) wr(DATA_OFS, 32'hcafe_0000 + i);
        wr(START_OFS, 32'h0000_0100);
        wait_busy(len);
        rd_reg(STAT_OFS);
        chk("digest done", rd, 32'h0000_0001);
        chk("done masked", {31'h0, irq}, 32'h0);
        wr(STAT_OFS, 32'h0000_0001);
    endtask

    // DMA suspend, save, init, restore, resume
    task dma_swap;
        int len;
        logic [31:0] m, c;
        wr(CTRL_OFS, 32'h0000_0004);
        chan_on <= 1'b1;
        wr(CTRL_OFS, 32'h0000_0008);
        poll(STAT_BUSY_BIT, 1'b1);
        chan_on <= 1'b0;
        wr(CTRL_OFS, 32'h0000_0000);
        poll(STAT_BUSY_BIT, 1'b0);
        chk("no digest", {31'h0, rd[STAT_DONE_BIT]}, 32'h0);
        chk("word count", {27'h0, rd[12:8]}, {24'h0, sent - 8'h10});
        rd_reg(MASK_OFS);
        m = rd;
        rd_reg(CTRL_OFS);
        c = rd;
        for (int i = 0; i < CSR_NUM; i++) begin
            rd_reg(CSR_OFS + 12'(4 * i));
            ctx[i] = rd;
        end
        wr(MASK_OFS, m);
        wr(START_OFS, 32'h0000_0000);
        wr(CTRL_OFS, c);
        wr(CTRL_OFS, 32'h0000_0004);
        rd_reg(CSR_OFS);
        chk("init clears", rd, 32'h0000_0000);
        for (int i = 0; i < CSR_NUM; i++) begin
            if (!(i >= 22 && i <= 37 && ctx[21] == 32'h0)) begin
                wr(CSR_OFS + 12'(4 * i), ctx[i]);
            end
        end
        for (int i = 0; i < CSR_NUM; i++) begin
            rd_reg(CSR_OFS + 12'(4 * i));
            if (i >= 22 && i <= 37 && ctx[21] == 32'h0) begin
                chk("skipped word", rd, 32'h0000_0000);
            end else begin
                chk("restored word", rd, ctx[i]);
            end
        end
        slow <= 1'b1;
        chan_on <= 1'b1;
        wr(CTRL_OFS, 32'h0000_0008);
        wait_busy(len);
        chk("resumed span", 32'(len), 32'(BLOCK_ROUNDS));
        chk("words resumed", {31'h0, sent >= 8'h20}, 32'h1);
        chan_on <= 1'b0;
        wr(CTRL_OFS, 32'h0000_0000);
    endtask

    // CPU-fed suspend between blocks, other message, restore, feed on
    task cpu_swap;
        logic [31:0] ref_st [0:7];
        logic [31:0] m, s, c;
        // Reference: the same 32 words without interruption
        wr(CTRL_OFS, 32'h0000_0004);
        for (int i = 0; i < 32; i++) begin
            wr(DATA_OFS, 32'h5a00_0000 + i);
            if (i % 16 == 15) poll(STAT_BUSY_BIT, 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            rd_reg(CSR_OFS + 12'(4 * i));
            ref_st[i] = rd;
        end
        // First block only, in keyed mode, then suspend
        wr(CTRL_OFS, 32'h0000_0044);
        for (int i = 0; i < 16; i++) begin
            wr(DATA_OFS, 32'h5a00_0000 + i);
        end
        poll(STAT_BUSY_BIT, 1'b0);
        chk("cpu ready", {31'h0, rd[STAT_INRDY_BIT]}, 32'h1);
        rd_reg(MASK_OFS);
        m = rd;
        rd_reg(START_OFS);
        s = rd;
        rd_reg(CTRL_OFS);
        c = rd;
        chk("read okay", {30'h0, rs}, {30'h0, RESP_OKAY});
        chk("keyed mode", c, 32'h0000_0040);
        for (int i = 0; i < CSR_NUM; i++) begin
            rd_reg(CSR_OFS + 12'(4 * i));
            ctx[i] = rd;
        end
        // Another message borrows the unit
        wr(CTRL_OFS, 32'h0000_0004);
        for (int i = 0; i < 5; i++) wr(DATA_OFS, 32'h0bad_0000 + i);
        wr(MASK_OFS, m);
        wr(START_OFS, s);
        wr(CTRL_OFS, c);
        wr(CTRL_OFS, c | 32'h0000_0004);
        for (int i = 0; i < CSR_NUM; i++) begin
            wr(CSR_OFS + 12'(4 * i), ctx[i]);
        end
        for (int i = 16; i < 32; i++) begin
            wr(DATA_OFS, 32'h5a00_0000 + i);
        end
        poll(STAT_BUSY_BIT, 1'b0);
        for (int i = 0; i < 8; i++) begin
            rd_reg(CSR_OFS + 12'(4 * i));
            chk("resumed digest", rd, ref_st[i]);
        end
    endtask

    // Verdict and end of run
    task give_verdict;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        reset_values();
        cpu_block();
        final_digest();
        dma_swap();
        cpu_swap();
        give_verdict();
    end

    // Watchdog against a hang
    initial begin
        #(25 * 40000);
        miscompares++;
        give_verdict();
    end
endmodule // hash_context_swap_bench
